// file: hdl/serial_interface.sv
// Full-duplex asynchronous serial interface with wake-up and sync clock
//
// The implementer's own choices: the address map and the strobed register port.
`timescale 1ns/1ns
module serial_interface
    import serial_interface_pkg::*;
(
    input wire logic CLK_IN,
    input wire logic RST_B_IN,
    input wire logic [ADDR_W-1:0] ADDR_IN,
    input wire logic [DATA_W-1:0] WDATA_IN,
    input wire logic WR_IN,
    input wire logic RD_IN,
    output logic [DATA_W-1:0] RDATA_OUT,
    output logic IRQ_OUT,
    input wire logic RXD_IN,
    output logic TXD_OUT,
    output logic TXD_OE_OUT,
    output logic SCLK_OUT,
    output logic SCLK_OE_OUT
);
    function automatic logic [7:0] sel_limit(input logic [2:0] sel);
        sel_limit = 8'((9'h001 << sel) - 9'h001);
    endfunction

    function automatic logic vote(input logic a, input logic b,
                                  input logic c);
        vote = (a & b) | (a & c) | (b & c);
    endfunction

    logic [7:0] rate, ctrl1, ctrl2;
    logic [7:0] tx_hold;
    logic transmit_empty_flag, tc, receive_full_flag, idle_flag, ovr, noise, frame_err;
    logic status_seen;
    logic [8:0] rx_data;
    logic rx_meta, rx_s;
    logic [7:0] pre_cnt, rxd_cnt, txd_cnt;
    logic pre_tick, rx_tick, tx16_tick;
    rx_state_e rx_state;
    tx_state_e tx_state;
    logic [3:0] rt_cnt, rx_bit;
    logic [1:0] samp;
    logic [8:0] rx_sh;
    logic rx_noisy, rx_all_zero, char_seen;
    logic [7:0] ones_cnt;
    logic [3:0] tx_phase, tx_left, tx_num;
    logic [10:0] tx_sh;
    logic tx_is_data, preamble_pend, te_d;

    wire te = ctrl2[C2_TE];
    wire re = ctrl2[C2_RE];
    wire sleep = ctrl2[C2_SLEEP];
    wire nine = ctrl1[C1_M];
    wire [3:0] nbits = nine ? DATA_BITS_9 : DATA_BITS_8;
    wire [7:0] idle_rt = nine ? IDLE_RT_9 : IDLE_RT_8;
    wire wr_data = WR_IN && ADDR_IN == ADDR_DATA;
    wire rd_data = RD_IN && ADDR_IN == ADDR_DATA;
    wire rd_stat = RD_IN && ADDR_IN == ADDR_STATUS;
    wire [7:0] status = {transmit_empty_flag, tc, receive_full_flag, idle_flag, ovr, noise, frame_err,
                         1'b0};
    wire [1:0] pre_sel = rate[RATE_PRE_LSB +: 2];
    wire [7:0] pre_lim = pre_sel == 2'h0 ? PRE_DIV0 :
                         pre_sel == 2'h1 ? PRE_DIV1 :
                         pre_sel == 2'h2 ? PRE_DIV2 : PRE_DIV3;

    // Register read mux
    wire [7:0] rd_mux =
        ADDR_IN == ADDR_RATE ? rate :
        ADDR_IN == ADDR_CTRL1 ? {rx_data[8], ctrl1[6:0]} :
        ADDR_IN == ADDR_CTRL2 ? ctrl2 :
        ADDR_IN == ADDR_STATUS ? status :
        ADDR_IN == ADDR_DATA ? rx_data[7:0] : 8'h00;

    // Receiver frame decode
    wire rx_at_c = rx_state == RX_FRAME && rx_tick && rt_cnt == SAMPLE_C;
    wire rx_v = vote(samp[1], samp[0], rx_s);
    wire rx_dis = (samp[1] != samp[0]) || (samp[0] != rx_s);
    wire rx_stop = rx_at_c && rx_bit == nbits + 4'h1;
    wire [8:0] rx_word = nine ? rx_sh : {1'b0, rx_sh[8:1]};
    wire addr_mark = nine ? rx_sh[8] : rx_sh[8];
    wire am_wake = rx_stop && sleep && ctrl1[C1_WAKE] && addr_mark;
    wire rx_done = rx_stop && (!sleep || am_wake);
    wire idle_hit = rx_state == RX_WAIT && rx_tick && rx_s
                    && ones_cnt == idle_rt - 8'h01;
    wire idle_wake = idle_hit && sleep && !ctrl1[C1_WAKE];
    wire clr_rx = rd_data && status_seen;

    // Transmitter frame decode
    wire tx_bit_tick = tx16_tick && tx_phase == RT_LAST;
    wire tx_start = tx_state == TX_IDLE && tx_bit_tick;
    wire start_pre = tx_start && te && preamble_pend;
    wire start_dat = tx_start && te && !preamble_pend && !transmit_empty_flag;
    wire start_brk = tx_start && te && !preamble_pend && transmit_empty_flag
                     && ctrl2[C2_BRK];
    wire tx_end = tx_state == TX_SHIFT && tx_bit_tick && tx_left == 4'h1;
    wire pending = te && (preamble_pend || !transmit_empty_flag || ctrl2[C2_BRK]);
    wire [3:0] clk_last = ctrl1[C1_LBCL] ? nbits : nbits - 4'h1;
    wire sclk_on = tx_state == TX_SHIFT && tx_is_data
                   && tx_num >= 4'h1 && tx_num <= clk_last;
    wire sclk_half = ctrl1[C1_CPHA] ? ~tx_phase[3] : tx_phase[3];
    wire irq_next = (ctrl2[C2_TIE] && transmit_empty_flag) || (ctrl2[C2_COMPLETE_INTERRUPT_ENABLE] && tc)
                    || (ctrl2[C2_RIE] && (receive_full_flag || ovr))
                    || (ctrl2[C2_ILIE] && idle_flag);

    // Bus slave
    always_ff @(posedge CLK_IN)
    begin
        if (!RST_B_IN)
        begin
            rate <= RESET_RATE;
            ctrl1 <= RESET_CTRL;
            ctrl2 <= RESET_CTRL;
            tx_hold <= 8'h00;
            RDATA_OUT <= 8'h00;
            status_seen <= 1'b0;
        end
        else
        begin
            // relied on: rate written only while both disabled
            if (WR_IN && ADDR_IN == ADDR_RATE)
                rate <= WDATA_IN;
            if (WR_IN && ADDR_IN == ADDR_CTRL1)
                ctrl1 <= WDATA_IN;
            // hardware wake clears sleep; software write also can
            if (WR_IN && ADDR_IN == ADDR_CTRL2)
                ctrl2 <= WDATA_IN;
            else if (am_wake || idle_wake)
                ctrl2[C2_SLEEP] <= 1'b0;
            if (wr_data)
                tx_hold <= WDATA_IN;
            RDATA_OUT <= RD_IN ? rd_mux : 8'h00;
            if (rd_stat)
                status_seen <= 1'b1;
            else if (rd_data)
                status_seen <= 1'b0;
        end
    end

    always_ff @(posedge CLK_IN)
    begin
        if (!RST_B_IN)
        begin
            pre_cnt <= 8'h00;
            rxd_cnt <= 8'h00;
            txd_cnt <= 8'h00;
            pre_tick <= 1'b0;
            rx_tick <= 1'b0;
            tx16_tick <= 1'b0;
        end
        else
        begin
            pre_tick <= pre_cnt >= pre_lim - 8'h01;
            pre_cnt <= pre_cnt >= pre_lim - 8'h01 ? 8'h00 : pre_cnt + 8'h01;
            rx_tick <= 1'b0;
            tx16_tick <= 1'b0;
            if (pre_tick)
            begin
                rx_tick <= rxd_cnt >= sel_limit(rate[RATE_RX_LSB +: 3]);
                tx16_tick <= txd_cnt >= sel_limit(rate[RATE_TX_LSB +: 3]);
                rxd_cnt <= rxd_cnt >= sel_limit(rate[RATE_RX_LSB +: 3]) ?
                           8'h00 : rxd_cnt + 8'h01;
                txd_cnt <= txd_cnt >= sel_limit(rate[RATE_TX_LSB +: 3]) ?
                           8'h00 : txd_cnt + 8'h01;
            end
        end
    end

    // Pin synchroniser; only rx_s is read by logic
    always_ff @(posedge CLK_IN)
    begin
        if (!RST_B_IN)
        begin
            rx_meta <= 1'b1;
            rx_s <= 1'b1;
        end
        else
        begin
            rx_meta <= RXD_IN;
            rx_s <= rx_meta;
        end
    end

    // Receiver at sixteen ticks per bit
    always_ff @(posedge CLK_IN)
    begin
        if (!RST_B_IN || !re)
        begin
            rx_state <= RX_WAIT;
            rt_cnt <= 4'h0;
            rx_bit <= 4'h0;
            samp <= 2'h0;
            rx_sh <= 9'h000;
            rx_noisy <= 1'b0;
            rx_all_zero <= 1'b0;
            ones_cnt <= 8'h00;
        end
        else if (rx_tick)
        begin
            case (rx_state)
                RX_WAIT:
                begin
                    ones_cnt <= rx_s && ones_cnt != idle_rt ?
                                ones_cnt + 8'h01 : (rx_s ? ones_cnt : 8'h00);
                    if (!rx_s)
                    begin
                        rx_state <= RX_FRAME;
                        rt_cnt <= 4'h1;
                        rx_bit <= 4'h0;
                        rx_noisy <= 1'b0;
                        rx_all_zero <= 1'b1;
                    end
                end
                RX_FRAME:
                begin
                    ones_cnt <= 8'h00;
                    rt_cnt <= rt_cnt + 4'h1;
                    if (rt_cnt == SAMPLE_A || rt_cnt == SAMPLE_B)
                        samp <= {samp[0], rx_s};
                    if (rt_cnt == SAMPLE_C)
                    begin
                        rx_noisy <= rx_noisy | rx_dis;
                        rx_all_zero <= rx_all_zero & !rx_v;
                        if (rx_bit == 4'h0 && rx_v)
                            rx_state <= RX_WAIT;
                        else if (rx_bit == nbits + 4'h1)
                            rx_state <= RX_WAIT;
                        else if (rx_bit != 4'h0)
                            rx_sh <= {rx_v, rx_sh[8:1]};
                        rx_bit <= rx_bit + 4'h1;
                    end
                end
                default:
                    rx_state <= RX_WAIT;
            endcase
        end
    end

    // Receive flags; a hardware set beats a same-cycle clear
    always_ff @(posedge CLK_IN)
    begin
        if (!RST_B_IN)
        begin
            rx_data <= 9'h000;
            receive_full_flag <= 1'b0;
            idle_flag <= 1'b0;
            ovr <= 1'b0;
            noise <= 1'b0;
            frame_err <= 1'b0;
            char_seen <= 1'b0;
        end
        else
        begin
            if (clr_rx)
            begin
                receive_full_flag <= 1'b0;
                idle_flag <= 1'b0;
                ovr <= 1'b0;
                noise <= 1'b0;
                frame_err <= 1'b0;
            end
            if (rx_done)
            begin
                char_seen <= 1'b1;
                if (receive_full_flag && !clr_rx)
                    ovr <= 1'b1;
                else
                begin
                    rx_data <= rx_word;
                    receive_full_flag <= 1'b1;
                    noise <= rx_noisy | rx_dis;
                    // break gives framing error with zero data
                    frame_err <= !rx_v || (rx_all_zero && !rx_v);
                end
            end
            if (idle_hit && !sleep && char_seen)
            begin
                idle_flag <= 1'b1;
                char_seen <= 1'b0;
            end
        end
    end

    // Transmitter; sixteen tx16 ticks per bit
    always_ff @(posedge CLK_IN)
    begin
        if (!RST_B_IN)
        begin
            tx_state <= TX_IDLE;
            tx_phase <= 4'h0;
            tx_left <= 4'h0;
            tx_num <= 4'h0;
            tx_sh <= 11'h7FF;
            tx_is_data <= 1'b0;
            preamble_pend <= 1'b0;
            te_d <= 1'b0;
            transmit_empty_flag <= 1'b1;
            tc <= 1'b1;
        end
        else
        begin
            te_d <= te;
            if (tx16_tick)
                tx_phase <= tx_phase + 4'h1;
            if (te && !te_d)
                preamble_pend <= 1'b1;
            if (wr_data)
            begin
                transmit_empty_flag <= 1'b0;
                tc <= 1'b0;
            end
            case (tx_state)
                TX_IDLE:
                    if (start_pre || start_dat || start_brk)
                    begin
                        tx_state <= TX_SHIFT;
                        tx_num <= 4'h0;
                        tx_left <= nbits + 4'h2;
                        tx_is_data <= start_dat;
                        tc <= 1'b0;
                        if (start_pre)
                        begin
                            preamble_pend <= 1'b0;
                            tx_sh <= 11'h7FF;
                        end
                        // break is a full frame of zeros
                        else if (start_brk)
                            tx_sh <= 11'h000;
                        // load frame and mark holding empty
                        else
                        begin
                            tx_sh <= nine ?
                                {1'b1, ctrl1[C1_T8], tx_hold, 1'b0} :
                                {2'b11, tx_hold, 1'b0};
                            transmit_empty_flag <= 1'b1;
                        end
                    end
                    // disabled with empty shifter shows complete
                    else if (!te)
                        tc <= 1'b1;
                TX_SHIFT:
                    // frame runs to the end even if disabled
                    if (tx_bit_tick)
                    begin
                        tx_sh <= {1'b1, tx_sh[10:1]};
                        tx_num <= tx_num + 4'h1;
                        tx_left <= tx_left - 4'h1;
                        if (tx_end)
                        begin
                            tx_state <= TX_IDLE;
                            if (!pending)
                                tc <= 1'b1;
                        end
                    end
                default:
                    tx_state <= TX_IDLE;
            endcase
        end
    end

    // Pin drivers
    always_ff @(posedge CLK_IN)
    begin
        if (!RST_B_IN)
        begin
            TXD_OUT <= 1'b1;
            TXD_OE_OUT <= 1'b0;
            SCLK_OUT <= 1'b0;
            SCLK_OE_OUT <= 1'b0;
            IRQ_OUT <= 1'b0;
        end
        else
        begin
            TXD_OUT <= tx_state == TX_SHIFT ? tx_sh[0] : 1'b1;
            // release pins only when idle and disabled
            TXD_OE_OUT <= te || tx_state == TX_SHIFT;
            SCLK_OE_OUT <= te || tx_state == TX_SHIFT;
            SCLK_OUT <= ctrl1[C1_CPOL] ^ (sclk_on & sclk_half);
            IRQ_OUT <= irq_next;
        end
    end

    default clocking cb @(posedge CLK_IN);
    endclocking
    default disable iff (!RST_B_IN);

    AST_TX_START_LOW:
    assert property (tx_state == TX_SHIFT && tx_num == 4'h0 && tx_is_data
                     |=> !TXD_OUT)
        else $error("start bit not low");
    AST_TRANSMIT_EMPTY_FLAG_ON_LOAD:
    assert property (start_dat && !wr_data |=> transmit_empty_flag && tx_state == TX_SHIFT)
        else $error("load did not set empty flag");
    AST_TC_ON_END:
    assert property (tx_end && !pending && !wr_data |=> tc)
        else $error("complete flag missing");
    AST_OE_WHILE_BUSY:
    assert property (tx_state == TX_SHIFT |=> TXD_OE_OUT)
        else $error("output released mid-frame");
    AST_HIGHZ_OFF:
    assert property (!te && tx_state == TX_IDLE |=> !TXD_OE_OUT
                     && !SCLK_OE_OUT)
        else $error("pins driven while disabled");
    AST_RECEIVE_FULL_FLAG_ON_DONE:
    assert property (rx_done && !receive_full_flag |=> receive_full_flag && rx_data == $past(rx_word))
        else $error("receive full not set");
    AST_SLEEP_BLOCKS:
    assert property ($past(sleep) && sleep |-> !$rose(receive_full_flag)
                     && !$rose(idle_flag))
        else $error("flag set while asleep");
    AST_IDLE_NEEDS_CHAR:
    assert property ($rose(idle_flag) |-> $past(char_seen))
        else $error("idle without character");
    AST_SCLK_QUIET:
    assert property (tx_state == TX_IDLE |=> SCLK_OUT == $past(ctrl1[C1_CPOL]))
        else $error("clock toggled outside data");
    AST_NOISE_FLAG:
    assert property (rx_done && !receive_full_flag && (rx_noisy || rx_dis) |=> noise)
        else $error("noise not flagged");
    AST_IDLE_WAKE:
    assert property (idle_wake && !(WR_IN && ADDR_IN == ADDR_CTRL2)
                     |=> !sleep)
        else $error("idle wake failed");
endmodule

// file: hdl/serial_interface_pkg.sv
// Constants, register map and state types of the serial interface
package serial_interface_pkg;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 8;
    localparam logic [7:0] ADDR_RATE = 8'h0D;
    localparam logic [7:0] ADDR_CTRL1 = 8'h0E;
    localparam logic [7:0] ADDR_CTRL2 = 8'h0F;
    localparam logic [7:0] ADDR_STATUS = 8'h10;
    localparam logic [7:0] ADDR_DATA = 8'h11;
    // control_register_one fields
    localparam int C1_R8 = 7;
    localparam int C1_T8 = 6;
    localparam int C1_M = 4;
    localparam int C1_WAKE = 3;
    localparam int C1_CPOL = 2;
    localparam int C1_CPHA = 1;
    localparam int C1_LBCL = 0;
    // control_register_two fields
    localparam int C2_TIE = 7;
    localparam int C2_COMPLETE_INTERRUPT_ENABLE = 6;
    localparam int C2_RIE = 5;
    localparam int C2_ILIE = 4;
    localparam int C2_TE = 3;
    localparam int C2_RE = 2;
    localparam int C2_SLEEP = 1;
    localparam int C2_BRK = 0;
    // status_register fields
    localparam int S_TRANSMIT_EMPTY_FLAG = 7;
    localparam int S_TC = 6;
    localparam int S_RECEIVE_FULL_FLAG = 5;
    localparam int S_IDLE = 4;
    localparam int S_OR = 3;
    localparam int S_NF = 2;
    localparam int S_FE = 1;
    // Rate register: prescaler [7:6], transmit [5:3], receive [2:0]
    localparam int RATE_PRE_LSB = 6;
    localparam int RATE_TX_LSB = 3;
    localparam int RATE_RX_LSB = 0;
    localparam logic [7:0] PRE_DIV0 = 8'h01;
    localparam logic [7:0] PRE_DIV1 = 8'h03;
    localparam logic [7:0] PRE_DIV2 = 8'h04;
    localparam logic [7:0] PRE_DIV3 = 8'h0D;
    localparam logic [3:0] RT_LAST = 4'hF;
    // Vote samples at 8, 9 and 10 RT; 1 RT is count zero
    localparam logic [3:0] SAMPLE_A = 4'h7;
    localparam logic [3:0] SAMPLE_B = 4'h8;
    localparam logic [3:0] SAMPLE_C = 4'h9;
    localparam logic [3:0] DATA_BITS_8 = 4'h8;
    localparam logic [3:0] DATA_BITS_9 = 4'h9;
    localparam logic [7:0] IDLE_RT_8 = 8'hA0;
    localparam logic [7:0] IDLE_RT_9 = 8'hB0;
    localparam logic [7:0] RESET_CTRL = 8'h00;
    localparam logic [7:0] RESET_RATE = 8'h00;
    typedef enum logic [0:0] {RX_WAIT, RX_FRAME} rx_state_e;
    typedef enum logic [0:0] {TX_IDLE, TX_SHIFT} tx_state_e;
endpackage

// file: tb/remote_node.sv
// Far-end serial node: sends frames to the receiver, catches transmitted ones
`timescale 1ns/1ns
module remote_node #(
    parameter int BIT_CYC = 16
)
(
    input wire logic clk_in,
    input wire logic line_in,
    output logic line_out
);
    initial line_out = 1'b1;

    task automatic send_frame(input logic [8:0] data, input int nbits,
        input logic stop);
        @(posedge clk_in);
        line_out <= 1'b0;
        repeat (BIT_CYC) @(posedge clk_in);
        for (int i = 0; i < nbits; i++)
        begin
            line_out <= data[i];
            repeat (BIT_CYC) @(posedge clk_in);
        end
        line_out <= stop;
        repeat (BIT_CYC) @(posedge clk_in);
        line_out <= 1'b1;
    endtask

    // one-sample spike on the middle vote of data bit 0
    task automatic send_spiked(input logic [8:0] data, input int nbits);
        fork
            send_frame(data, nbits, 1'b1);
            begin
                repeat (BIT_CYC + BIT_CYC / 2 + 1) @(posedge clk_in);
                line_out <= ~data[0];
                @(posedge clk_in);
                line_out <= data[0];
            end
        join
    endtask

    task automatic catch_frame(input int nbits, output logic [8:0] data,
        output logic stop, output logic ok);
        int n;
        n = 0;
        data = '0;
        while (line_in !== 1'b0 && n < 3000)
        begin
            @(posedge clk_in);
            n++;
        end
        ok = (line_in === 1'b0);
        repeat (BIT_CYC / 2) @(posedge clk_in);
        for (int i = 0; i < nbits; i++)
        begin
            repeat (BIT_CYC) @(posedge clk_in);
            data[i] = line_in;
        end
        repeat (BIT_CYC) @(posedge clk_in);
        stop = line_in;
    endtask
endmodule

// file: tb/test_serial_interface.sv
// Self-checking bench for the serial interface
`timescale 1ns/1ns
module test_serial_interface
    import serial_interface_pkg::*;
;
    localparam int BIT_CYC = 16;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic [ADDR_W-1:0] addr = '0;
    logic [DATA_W-1:0] wdata = '0;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [DATA_W-1:0] rdata;
    logic irq, rxd, txd, txd_oe, sclk, sclk_oe;
    logic [7:0] v;
    logic [8:0] fr;
    logic stp;
    int n_mismatch = 0;
    int samples_checked = 0;
    int sclk_rises = 0;
    // Released wire rests high on its pull-up
    wire txd_line = txd_oe ? txd : 1'b1;

    always #50 clk = ~clk;
    always @(posedge sclk) sclk_rises++;

    serial_interface dut_u (.CLK_IN(clk), .RST_B_IN(rst_b), .ADDR_IN(addr),
        .WDATA_IN(wdata), .WR_IN(wr), .RD_IN(rd), .RDATA_OUT(rdata),
        .IRQ_OUT(irq), .RXD_IN(rxd), .TXD_OUT(txd), .TXD_OE_OUT(txd_oe),
        .SCLK_OUT(sclk), .SCLK_OE_OUT(sclk_oe));
    remote_node #(.BIT_CYC(BIT_CYC)) node_u (.clk_in(clk),
        .line_in(txd_line), .line_out(rxd));

    task automatic wrap_up;
        if (n_mismatch == 0 && samples_checked > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [7:0] m,
        input logic [7:0] e);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1 v = rdata;
        check(v & m, e);
    endtask

    task automatic catch(input int nbits);
        logic k;
        node_u.catch_frame(nbits, fr, stp, k);
        if (k !== 1'b1)
        begin
            n_mismatch++;
            wrap_up;
        end
    endtask

    task automatic reset_values;
        rd_chk(ADDR_STATUS, 8'hFF, 8'hC0); // flags after reset
        rd_chk(ADDR_CTRL2, 8'hFF, 8'h00); // control cleared
        rd_chk(8'h3F, 8'hFF, 8'h00);
        check({7'h00, txd_oe}, 8'h00); // output released
    endtask

    task automatic send_path;
        wr_reg(ADDR_RATE, 8'h00); // rate set while disabled
        wr_reg(ADDR_CTRL1, 8'h00);
        wr_reg(ADDR_CTRL2, 8'h08);
        sclk_rises = 0;
        wr_reg(ADDR_DATA, 8'hA5);
        rd_chk(ADDR_STATUS, 8'hC0, 8'h00); // byte waits behind preamble
        catch(8);
        check(fr[7:0], 8'hA5); // LSB first at bit rate
        check({7'h00, stp}, 8'h01); // stop high
        check(8'(sclk_rises), 8'h07); // clock on data bits but last
        repeat (BIT_CYC) @(posedge clk);
        rd_chk(ADDR_STATUS, 8'hC0, 8'hC0); // empty and complete
        wr_reg(ADDR_DATA, 8'h5A);
        fork
            catch(8);
            begin
                repeat (3 * BIT_CYC) @(posedge clk);
                wr_reg(ADDR_CTRL2, 8'h00);
                check({7'h00, txd_oe}, 8'h01); // pin kept mid-frame
            end
        join
        check(fr[7:0], 8'h5A); // character finished
        repeat (BIT_CYC) @(posedge clk);
        check({6'h00, txd_oe, sclk_oe}, 8'h00); // both released
        rd_chk(ADDR_STATUS, 8'h40, 8'h40); // complete after disable
    endtask

    task automatic recv_path;
        wr_reg(ADDR_CTRL2, 8'h24);
        repeat (200) @(posedge clk);
        rd_chk(ADDR_STATUS, 8'h3E, 8'h00); // no idle before a character
        node_u.send_frame(9'h03C, 8, 1'b1);
        repeat (4) @(posedge clk);
        check({7'h00, irq}, 8'h01); // receive interrupt
        rd_chk(ADDR_STATUS, 8'h2E, 8'h20); // full, no noise
        rd_chk(ADDR_DATA, 8'hFF, 8'h3C); // last byte
        node_u.send_spiked(9'h0F0, 8);
        repeat (4) @(posedge clk);
        rd_chk(ADDR_STATUS, 8'h2E, 8'h24); // spike sets noise
        rd_chk(ADDR_DATA, 8'hFF, 8'hF0); // majority keeps the bit
        node_u.send_frame(9'h011, 8, 1'b1);
        node_u.send_frame(9'h022, 8, 1'b1);
        repeat (4) @(posedge clk);
        rd_chk(ADDR_STATUS, 8'h2E, 8'h28); // overrun
        rd_chk(ADDR_DATA, 8'hFF, 8'h11); // later byte dropped
        node_u.send_frame(9'h000, 8, 1'b0);
        repeat (4) @(posedge clk);
        rd_chk(ADDR_STATUS, 8'h02, 8'h02); // break framing error
        rd_chk(ADDR_DATA, 8'hFF, 8'h00); // break reads zero
        wr_reg(ADDR_CTRL2, 8'h34);
        repeat (200) @(posedge clk);
        check({7'h00, irq}, 8'h01); // idle interrupt
        rd_chk(ADDR_STATUS, 8'h10, 8'h10); // idle after character
    endtask

    task automatic wake_path;
        rd_chk(ADDR_STATUS, 8'h3E, 8'h10); // idle still pending
        rd_chk(ADDR_DATA, 8'hFF, 8'h00); // break data kept
        wr_reg(ADDR_CTRL1, 8'h08);
        wr_reg(ADDR_CTRL2, 8'h06);
        node_u.send_frame(9'h012, 8, 1'b1);
        repeat (4) @(posedge clk);
        rd_chk(ADDR_STATUS, 8'h3E, 8'h00); // flags held while asleep
        rd_chk(ADDR_CTRL2, 8'hFF, 8'h06); // data character ignored
        node_u.send_frame(9'h085, 8, 1'b1);
        repeat (4) @(posedge clk);
        rd_chk(ADDR_CTRL2, 8'hFF, 8'h04); // address wakes
        rd_chk(ADDR_STATUS, 8'h20, 8'h20); // address loaded
        rd_chk(ADDR_DATA, 8'hFF, 8'h85); // address byte
        wr_reg(ADDR_CTRL1, 8'h00);
        wr_reg(ADDR_CTRL2, 8'h06);
        node_u.send_frame(9'h000, 8, 1'b1);
        rd_chk(ADDR_CTRL2, 8'hFF, 8'h06); // still asleep
        repeat (200) @(posedge clk);
        rd_chk(ADDR_CTRL2, 8'hFF, 8'h04); // idle line wakes
    endtask

    task automatic nine_path;
        wr_reg(ADDR_CTRL1, 8'h55);
        wr_reg(ADDR_CTRL2, 8'h08);
        sclk_rises = 0;
        wr_reg(ADDR_DATA, 8'h3C);
        catch(9);
        check(fr[7:0], 8'h3C); // nine-bit frame
        check({7'h00, fr[8]}, 8'h01); // ninth bit from control
        check({7'h00, stp}, 8'h01); // stop high
        check(8'(sclk_rises), 8'h09); // last bit clocked, inverted
        wr_reg(ADDR_CTRL2, 8'h09);
        catch(9);
        check(fr[7:0], 8'h00); // break zeros
        check({7'h00, fr[8], stp}, 8'h00); // eleven zero bits
        wr_reg(ADDR_CTRL2, 8'h40);
        repeat (2) @(posedge clk);
        check({7'h00, irq}, 8'h00); // break still in flight
        repeat (BIT_CYC) @(posedge clk);
        check({7'h00, irq}, 8'h01); // complete interrupt
        check(8'(sclk_rises), 8'h09); // no clock during break
    endtask

    initial
    begin
        repeat (2) @(posedge clk);
        rst_b <= 1'b1;
        reset_values;
        send_path;
        recv_path;
        wake_path;
        nine_path;
        wrap_up;
    end

    initial
    begin
        repeat (30000) @(posedge clk);
        n_mismatch++;
        wrap_up;
    end
endmodule
